// *** src/cmh_pkg.sv ***
package cmh_pkg;

    localparam int NUM_WORDS = 10;

    // Input image word indices
    localparam logic [3:0] W_CFG0 = 4'h0;
    localparam logic [3:0] W_CFG1 = 4'h1;
    localparam logic [3:0] W_SPD_UP = 4'h2;
    localparam logic [3:0] W_SPD_LO = 4'h3;
    localparam logic [3:0] W_STEPS = 4'h4;
    localparam logic [3:0] W_ZERO = 4'h5;
    localparam logic [3:0] W_ENC_RES = 4'h6;
    localparam logic [3:0] W_IDLE = 4'h7;
    localparam logic [3:0] W_MOTOR_I = 4'h8;
    localparam logic [3:0] W_SAVE_ST = 4'h9;

    // Configuration word 0 fields
    localparam int C0_MODE = 15;
    localparam int C0_STALL_EN = 13;
    localparam int C0_ENC_EN = 10;
    localparam int C0_IN3_LSB = 6;
    localparam int C0_IN2_LSB = 3;
    localparam int C0_IN1_LSB = 0;
    localparam logic [15:0] C0_RSVD_MASK = 16'h1200;

    // Configuration word 1 fields
    localparam int C1_FETCH = 11;
    localparam int C1_PERSIST = 10;
    localparam int C1_RPT_FMT = 9;
    localparam int C1_PRM_FMT = 8;
    localparam logic [15:0] C1_RSVD_MASK = 16'h70f8;

    localparam logic [2:0] FN_GPI = 3'h0;
    localparam logic [2:0] FN_RSVD = 3'h7;

    // Parameter ranges
    localparam logic [15:0] SPD_LO_MAX = 16'h03e7;
    localparam logic [15:0] IDLE_MAX = 16'h0064;
    localparam logic [15:0] MOTOR_I_MIN = 16'h0001;
    localparam logic [15:0] MOTOR_I_MAX = 16'h0036;
    localparam logic [15:0] STEPS_MIN = 16'h00c8;
    localparam logic [15:0] STEPS_MAX = 16'h7fff;

    localparam logic [15:0] SAVE_OK = 16'haaaa;
    localparam logic [15:0] SAVE_FAIL = 16'heeee;
    localparam logic [15:0] CFG_ERR_STATUS = 16'h6408;
    localparam logic [15:0] MULTIWORD_SCALE = 16'h03e8;

    localparam logic [15:0] RESET_WORD = 16'h0000;

    typedef enum logic [1:0] {
        LED_OFF,
        LED_FLASH_GREEN,
        LED_FLASH_RED
    } cmh_led_t;

    typedef struct packed {
        logic report_wide_format;
        logic param_wide_format;
        logic third_input_polarity;
        logic second_input_polarity;
        logic first_input_polarity;
    } cmh_mode_t;

    typedef logic [NUM_WORDS-1:0][15:0] cmh_image_t;

endpackage

// *** src/cmh_config_mode_handler.sv ***
`timescale 1ns/1ps
`default_nettype none

module cmh_config_mode_handler
    import cmh_pkg::*;
(
    input wire logic CLK,                      // 50 MHz system clock
    input wire logic RST_B,                    // Power-on reset, active low
    input wire logic XCHG_VALID,               // Output image exchange strobe
    input wire cmh_image_t OUT_WORDS,          // Ten output words from host
    input wire logic CONN_EST,                 // Pulse: connection established
    input wire logic DESC_PATH,                // Setup came via descriptor file
    input wire logic FLASH_HAS_CFG,            // Flash holds a saved setup
    input wire cmh_image_t FLASH_WORDS,        // Setup read from flash
    input wire logic FLASH_DONE,               // Flash write finished
    input wire logic FLASH_OK,                 // Flash write succeeded
    input wire logic MOVE_DONE,                // Pulse: a move completed
    input wire logic [2:0] IN_CURRENT,         // Raw current-flow on inputs 1-3
    input wire logic [15:0] WIDE_HI_IN,        // Command word pair: even word
    input wire logic [15:0] WIDE_LO_IN,        // Command word pair: odd word
    input wire logic signed [31:0] POS_IN,     // Position value to report
    output logic FLASH_WR,                     // Pulse: start flash write
    output cmh_image_t FLASH_WDATA,            // Setup to write to flash
    output cmh_image_t IN_WORDS,               // Ten input words to host
    output logic CONFIGURED,                   // Valid setup committed
    output logic CFG_ERROR,                    // Configuration error flag
    output logic MOTOR_EN,                     // Motor may be powered
    output logic CMD_ACCEPT,                   // Commands may be accepted
    output logic HALTED,                       // Stopped after save response
    output cmh_led_t MOD_LED,                  // Module status indicator
    output cmh_mode_t MODE,                    // Committed format and polarity
    output logic [2:0] IN_ACTIVE,              // Inputs 1-3 after polarity
    output logic [15:0] IDLE_CURRENT,          // Idle current in force
    output logic signed [31:0] WIDE_PARAM,     // Decoded wide command parameter
    output logic signed [31:0] START_SPEED,    // Decoded starting speed
    output logic [15:0] POS_RPT_EVEN,          // Reported position, even word
    output logic [15:0] POS_RPT_ODD            // Reported position, odd word
);

    // Synchronised current-flow inputs 1-3
    logic [2:0] in_meta_reg;
    logic [2:0] in_sync_reg;

    cmh_image_t cfg_reg;
    cmh_image_t img_reg;
    logic configured_reg;
    logic halted_reg;
    logic save_busy_reg;
    logic persist_prev_reg;
    logic cfg_mode_prev_reg;
    logic fetch_hold_reg;
    logic flash_loaded_reg;
    logic [15:0] idle_pending_reg;
    logic [15:0] idle_reg;
    logic idle_wait_reg;
    logic flash_wr_reg;
    cmh_led_t led_reg;
    logic [15:0] save_status_reg;
    logic [15:0] pos_even_reg;
    logic [15:0] pos_odd_reg;
    logic signed [31:0] wide_reg;
    logic signed [31:0] speed_reg;

    logic cfg_mode;
    logic [15:0] w0;
    logic [15:0] w1;
    logic [2:0] f1, f2, f3;
    logic rsvd_bad, range_bad, dup_bad, stall_bad, code_bad, cand_valid;
    logic persist_rise;
    logic write_ok;

    assign w0 = OUT_WORDS[W_CFG0];
    assign w1 = OUT_WORDS[W_CFG1];
    assign cfg_mode = XCHG_VALID && w0[C0_MODE];
    assign f1 = w0[C0_IN1_LSB +: 3];
    assign f2 = w0[C0_IN2_LSB +: 3];
    assign f3 = w0[C0_IN3_LSB +: 3];

    // Every check is looked at together over words 0, 1, 3-5 and 7-9; words 2 and 6 are not checked
    always_comb begin
        rsvd_bad = |(w0 & C0_RSVD_MASK) || |(w1 & C1_RSVD_MASK)
            || (OUT_WORDS[W_ZERO] != RESET_WORD)
            || (OUT_WORDS[W_SAVE_ST] != RESET_WORD);
        range_bad = (OUT_WORDS[W_SPD_LO] > SPD_LO_MAX)
            || (OUT_WORDS[W_IDLE] > IDLE_MAX)
            || (OUT_WORDS[W_MOTOR_I] < MOTOR_I_MIN)
            || (OUT_WORDS[W_MOTOR_I] > MOTOR_I_MAX)
            || (OUT_WORDS[W_STEPS] < STEPS_MIN)
            || (OUT_WORDS[W_STEPS] > STEPS_MAX);
        dup_bad = ((f1 == f2) && (f1 != FN_GPI))
            || ((f1 == f3) && (f1 != FN_GPI))
            || ((f2 == f3) && (f2 != FN_GPI));
        stall_bad = w0[C0_STALL_EN] && !w0[C0_ENC_EN];
        code_bad = (f1 == FN_RSVD) || (f2 == FN_RSVD) || (f3 == FN_RSVD);
        cand_valid = !(rsvd_bad || range_bad || dup_bad || stall_bad || code_bad);
    end

    assign persist_rise = cfg_mode && w1[C1_PERSIST] && !persist_prev_reg;
    assign write_ok = cfg_mode && !fetch_hold_reg && !w1[C1_FETCH] && !halted_reg;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            in_meta_reg <= 3'h0;
            in_sync_reg <= 3'h0;
        end else begin
            in_meta_reg <= IN_CURRENT;
            in_sync_reg <= in_meta_reg;
        end
    end

    // Fetch flag tracking at mode entry
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            cfg_mode_prev_reg <= 1'b0;
            fetch_hold_reg <= 1'b0;
            persist_prev_reg <= 1'b0;
        end else if (XCHG_VALID && !halted_reg) begin
            cfg_mode_prev_reg <= w0[C0_MODE];
            persist_prev_reg <= cfg_mode && w1[C1_PERSIST];
            if (cfg_mode && !cfg_mode_prev_reg) begin
                fetch_hold_reg <= w1[C1_FETCH];
            end else if (!cfg_mode || !w1[C1_FETCH]) begin
                fetch_hold_reg <= 1'b0;
            end
        end
    end

    // Committed setup store
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            cfg_reg <= '0;
            configured_reg <= 1'b0;
            flash_loaded_reg <= 1'b0;
        end else if (!halted_reg) begin
            if (write_ok && cand_valid) begin
                cfg_reg <= OUT_WORDS;
                configured_reg <= 1'b1;
                flash_loaded_reg <= 1'b1;
            end else if (!flash_loaded_reg && FLASH_HAS_CFG) begin
                cfg_reg <= FLASH_WORDS;
                configured_reg <= 1'b1;
                flash_loaded_reg <= 1'b1;
            end else if (write_ok && !cand_valid && CONN_EST) begin
                configured_reg <= configured_reg;
            end
            // Host setup at connection beats flash since flash only loads once
            if (CONN_EST && write_ok && cand_valid) begin
                flash_loaded_reg <= 1'b1;
            end
        end
    end

    // Save sequence; halts forever once answered
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            save_busy_reg <= 1'b0;
            flash_wr_reg <= 1'b0;
            halted_reg <= 1'b0;
            led_reg <= LED_OFF;
            save_status_reg <= RESET_WORD;
        end else begin
            flash_wr_reg <= 1'b0;
            if (!halted_reg && !save_busy_reg && persist_rise && cand_valid) begin
                save_busy_reg <= 1'b1;
                flash_wr_reg <= 1'b1;
            end else if (save_busy_reg && FLASH_DONE) begin
                save_busy_reg <= 1'b0;
                halted_reg <= 1'b1;
                if (FLASH_OK) begin
                    save_status_reg <= SAVE_OK;
                    led_reg <= LED_FLASH_GREEN;
                end else begin
                    save_status_reg <= SAVE_FAIL;
                    led_reg <= LED_FLASH_RED;
                end
            end
        end
    end

    // Idle current deferred to end of first move
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            idle_reg <= RESET_WORD;
            idle_pending_reg <= RESET_WORD;
            idle_wait_reg <= 1'b0;
        end else if (write_ok && cand_valid) begin
            idle_pending_reg <= OUT_WORDS[W_IDLE];
            idle_wait_reg <= 1'b1;
        end else if (idle_wait_reg && MOVE_DONE) begin
            idle_reg <= idle_pending_reg;
            idle_wait_reg <= 1'b0;
        end
    end

    // Input image: mirror in config mode (committed setup instead if fetch was set at entry), otherwise zeros with error status in word 0 while unconfigured
    // Held between exchanges so the host never reads a gap
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            img_reg <= '0;
        end else if (halted_reg) begin
            img_reg[W_SAVE_ST] <= save_status_reg;
        end else if (XCHG_VALID) begin
            if (w0[C0_MODE]) begin
                img_reg <= (fetch_hold_reg || (w1[C1_FETCH] && !cfg_mode_prev_reg))
                    ? cfg_reg : OUT_WORDS;
                img_reg[W_ZERO] <= RESET_WORD;
                img_reg[W_SAVE_ST] <= save_status_reg;
            end else begin
                img_reg <= '0;
                if (!configured_reg) begin
                    img_reg[W_CFG0] <= CFG_ERR_STATUS;
                end
            end
        end
    end

    // Format handling for wide values
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            wide_reg <= '0;
            speed_reg <= '0;
            pos_even_reg <= RESET_WORD;
            pos_odd_reg <= RESET_WORD;
        end else begin
            if (cfg_reg[W_CFG1][C1_PRM_FMT]) begin
                wide_reg <= {WIDE_LO_IN, WIDE_HI_IN};
            end else begin
                wide_reg <= 32'(signed'(WIDE_HI_IN) * signed'({16'h0, MULTIWORD_SCALE}))
                    + 32'(signed'(WIDE_LO_IN));
            end
            if (DESC_PATH && cfg_reg[W_CFG1][C1_PRM_FMT]) begin
                speed_reg <= {cfg_reg[W_SPD_LO], cfg_reg[W_SPD_UP]};
            end else begin
                speed_reg <= 32'(signed'(cfg_reg[W_SPD_UP])
                    * signed'({16'h0, MULTIWORD_SCALE}))
                    + 32'(signed'(cfg_reg[W_SPD_LO]));
            end
            if (cfg_reg[W_CFG1][C1_RPT_FMT]) begin
                pos_even_reg <= POS_IN[15:0];
                pos_odd_reg <= POS_IN[31:16];
            end else begin
                pos_even_reg <= 16'(POS_IN / 32'sd1000);
                pos_odd_reg <= 16'(POS_IN % 32'sd1000);
            end
        end
    end

    assign FLASH_WR = flash_wr_reg;
    assign FLASH_WDATA = cfg_reg;
    assign IN_WORDS = img_reg;
    assign CONFIGURED = configured_reg;
    assign CFG_ERROR = !configured_reg;
    assign MOTOR_EN = configured_reg && !halted_reg;
    assign CMD_ACCEPT = configured_reg && !halted_reg;
    assign HALTED = halted_reg;
    assign MOD_LED = led_reg;
    assign MODE = {cfg_reg[W_CFG1][C1_RPT_FMT], cfg_reg[W_CFG1][C1_PRM_FMT],
        cfg_reg[W_CFG1][2], cfg_reg[W_CFG1][1], cfg_reg[W_CFG1][0]};
    assign IN_ACTIVE = ~(in_sync_reg ^ cfg_reg[W_CFG1][2:0]);
    assign IDLE_CURRENT = idle_reg;
    assign WIDE_PARAM = wide_reg;
    assign START_SPEED = speed_reg;
    assign POS_RPT_EVEN = pos_even_reg;
    assign POS_RPT_ODD = pos_odd_reg;

    sequence s_ok_posted;
        led_reg == LED_FLASH_GREEN && save_status_reg == SAVE_OK && halted_reg
            ##1 img_reg[W_SAVE_ST] == SAVE_OK;
    endsequence
    property p_save_ok;
        @(posedge CLK) disable iff (!RST_B)
        save_busy_reg && FLASH_DONE && FLASH_OK |=> s_ok_posted;
    endproperty
    a_save_ok: assert property (p_save_ok) else $error("save success not posted");

    property p_save_fail;
        @(posedge CLK) disable iff (!RST_B)
        save_busy_reg && FLASH_DONE && !FLASH_OK |=> save_status_reg == SAVE_FAIL
            && led_reg == LED_FLASH_RED;
    endproperty
    a_save_fail: assert property (p_save_fail) else $error("save failure not posted");

    property p_halt_sticky;
        @(posedge CLK) disable iff (!RST_B)
        halted_reg |=> halted_reg && !CMD_ACCEPT;
    endproperty
    a_halt_sticky: assert property (p_halt_sticky) else $error("halt released");

    sequence s_bad_save;
        persist_rise && !cand_valid && !save_busy_reg;
    endsequence
    property p_bad_save_ignored;
        @(posedge CLK) disable iff (!RST_B)
        s_bad_save |=> !flash_wr_reg && !save_busy_reg;
    endproperty
    a_bad_save_ignored: assert property (p_bad_save_ignored) else $error("bad save ran");

    property p_good_save;
        @(posedge CLK) disable iff (!RST_B)
        persist_rise && cand_valid && !save_busy_reg && !halted_reg |=> flash_wr_reg;
    endproperty
    a_good_save: assert property (p_good_save) else $error("valid save not started");

    property p_stall;
        @(posedge CLK) disable iff (!RST_B)
        cfg_mode && w0[C0_STALL_EN] && !w0[C0_ENC_EN]
            && !(!flash_loaded_reg && FLASH_HAS_CFG) |=> $stable(cfg_reg);
    endproperty
    a_stall: assert property (p_stall) else $error("stall without encoder accepted");

    property p_speed_range;
        @(posedge CLK) disable iff (!RST_B)
        cfg_mode && (OUT_WORDS[W_SPD_LO] > SPD_LO_MAX)
            && !(!flash_loaded_reg && FLASH_HAS_CFG) |=> $stable(cfg_reg);
    endproperty
    a_speed_range: assert property (p_speed_range) else $error("speed word accepted");

    property p_fetch_refuse;
        @(posedge CLK) disable iff (!RST_B)
        cfg_mode && fetch_hold_reg && !(!flash_loaded_reg && FLASH_HAS_CFG)
            |=> $stable(cfg_reg);
    endproperty
    a_fetch_refuse: assert property (p_fetch_refuse) else $error("write while fetch set");

    property p_cfg_err;
        @(posedge CLK) disable iff (!RST_B)
        !configured_reg |-> CFG_ERROR && !MOTOR_EN;
    endproperty
    a_cfg_err: assert property (p_cfg_err) else $error("unconfigured but enabled");

    property p_cmd_status;
        @(posedge CLK) disable iff (!RST_B)
        XCHG_VALID && !w0[C0_MODE] && !configured_reg && !halted_reg
            |=> img_reg[W_CFG0] == CFG_ERR_STATUS;
    endproperty
    a_cmd_status: assert property (p_cmd_status) else $error("config error not shown");

    property p_idle_defer;
        @(posedge CLK) disable iff (!RST_B)
        write_ok && cand_valid |=> $stable(idle_reg);
    endproperty
    a_idle_defer: assert property (p_idle_defer) else $error("idle current applied early");

    property p_zero_word;
        @(posedge CLK) disable iff (!RST_B)
        cfg_mode && !halted_reg |=> img_reg[W_ZERO] == RESET_WORD;
    endproperty
    a_zero_word: assert property (p_zero_word) else $error("word 5 not zero");

endmodule // cmh_config_mode_handler

`default_nettype wire

// *** tb/cmh_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module cmh_flash_model
    import cmh_pkg::*;
(
    input wire logic CLK,               // System clock
    input wire logic RST_B,             // Reset, active low
    input wire logic FLASH_WR,          // Write request pulse
    input wire cmh_image_t FLASH_WDATA, // Setup to store
    input wire logic [3:0] LAT,         // Extra cycles before done
    input wire logic FAIL,              // Report the write as failed
    output logic FLASH_DONE,            // Write finished pulse
    output logic FLASH_OK               // Result, only valid with done
);
    cmh_image_t stored;
    logic [3:0] cnt;
    logic busy;

    // Storage survives reset, like the real part
    always_ff @(posedge CLK) begin
        if (FLASH_WR && !busy) begin
            stored <= FLASH_WDATA;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            FLASH_DONE <= 1'b0;
            FLASH_OK <= 1'b0;
        end else begin
            FLASH_DONE <= 1'b0;
            // Result line wanders outside done so a stale read is caught
            FLASH_OK <= ~FLASH_OK;
            if (FLASH_WR && !busy) begin
                busy <= 1'b1;
                cnt <= LAT;
            end else if (busy && cnt == 4'h0) begin
                busy <= 1'b0;
                FLASH_DONE <= 1'b1;
                FLASH_OK <= ~FAIL;
            end else if (busy) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule // cmh_flash_model

`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("BAD %s exp %h got %h", nm, exp, got); end end

module tb
    import cmh_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic xchg_valid = 1'b0;
    logic conn_est = 1'b0;
    logic desc_path = 1'b0;
    logic flash_has_cfg = 1'b0;
    logic move_done = 1'b0;
    logic fail = 1'b0;
    logic [3:0] lat = 4'h2;
    logic [2:0] in_current = 3'h0;
    logic [15:0] wide_hi_in = 16'h0000;
    logic [15:0] wide_lo_in = 16'h0000;
    logic signed [31:0] pos_in = 32'sh0;
    cmh_image_t out_words = '0;
    cmh_image_t flash_words = '0;
    logic flash_wr, flash_done, flash_ok, configured, cfg_error, motor_en, cmd_accept, halted;
    cmh_image_t flash_wdata, in_words, base, cfg;
    cmh_led_t mod_led;
    cmh_mode_t mode;
    logic [2:0] in_active;
    logic [15:0] idle_current, pos_rpt_even, pos_rpt_odd;
    logic signed [31:0] wide_param, start_speed;
    int n_mismatch = 0;
    int num_checks = 0;
    int n_wr = 0;
    int cidx[11] = '{1, 1, 0, 3, 7, 8, 0, 0, 0, 1, 0};
    logic [15:0] cval[11] = '{16'h4305, 16'h030d, 16'h9411, 16'h03e8, 16'h0065, 16'h0000,
        16'h8409, 16'ha011, 16'h8417, 16'h8305, 16'h8400};

    always #10 clk = ~clk;

    always @(negedge clk) begin
        if (flash_wr === 1'b1) n_wr++;
    end

    cmh_config_mode_handler dut (.CLK(clk), .RST_B(rst_b), .XCHG_VALID(xchg_valid),
        .OUT_WORDS(out_words), .CONN_EST(conn_est), .DESC_PATH(desc_path),
        .FLASH_HAS_CFG(flash_has_cfg), .FLASH_WORDS(flash_words), .FLASH_DONE(flash_done),
        .FLASH_OK(flash_ok), .MOVE_DONE(move_done), .IN_CURRENT(in_current),
        .WIDE_HI_IN(wide_hi_in), .WIDE_LO_IN(wide_lo_in), .POS_IN(pos_in),
        .FLASH_WR(flash_wr), .FLASH_WDATA(flash_wdata), .IN_WORDS(in_words),
        .CONFIGURED(configured), .CFG_ERROR(cfg_error), .MOTOR_EN(motor_en),
        .CMD_ACCEPT(cmd_accept), .HALTED(halted), .MOD_LED(mod_led), .MODE(mode),
        .IN_ACTIVE(in_active), .IDLE_CURRENT(idle_current), .WIDE_PARAM(wide_param),
        .START_SPEED(start_speed), .POS_RPT_EVEN(pos_rpt_even), .POS_RPT_ODD(pos_rpt_odd));

    cmh_flash_model flash (.CLK(clk), .RST_B(rst_b), .FLASH_WR(flash_wr),
        .FLASH_WDATA(flash_wdata), .LAT(lat), .FAIL(fail), .FLASH_DONE(flash_done),
        .FLASH_OK(flash_ok));

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // One exchange of ten words each way; image registers on the exchange edge, then two more edges pass
    task automatic xchg(input cmh_image_t w);
        xchg_valid = 1'b1;
        out_words = w;
        @(posedge clk);
        #1;
        xchg_valid = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic do_reset(input logic has_cfg);
        rst_b = 1'b0;
        flash_has_cfg = has_cfg;
        repeat (12) @(posedge clk);
        #1;
        rst_b = 1'b1;
        n_wr = 0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic save(input logic fail_sel, input logic [15:0] code, input cmh_led_t led);
        int i;
        fail = fail_sel;
        cfg = base;
        xchg(cfg);
        cfg[1] = base[1] | 16'h0400;
        xchg(cfg);
        for (i = 0; i < 40 && halted !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 40) begin
            n_mismatch++;
            $display("BAD halted exp 1 got %b", halted);
            complete_run();
        end
        repeat (2) @(posedge clk);
        #1;
        `CHK("flash_writes", 1, n_wr)
        `CHK("stored_word", base[8], flash.stored[8])
        `CHK("save_status", code, in_words[9])
        `CHK("led", led, mod_led)
        `CHK("cmd_after_save", 1'b0, cmd_accept)
        cfg[8] = 16'h0021;
        xchg(cfg);
        `CHK("frozen_image", base[8], in_words[8])
        `CHK("frozen_status", code, in_words[9])
    endtask

    initial begin
        int i;
        base = {16'h0000, 16'h0014, 16'h0032, 16'h0400, 16'h0000,
            16'h0190, 16'h00ea, 16'h0001, 16'h0305, 16'h8411};
        do_reset(1'b0);
        `CHK("cfg_error", 1'b1, cfg_error)
        `CHK("motor_en", 1'b0, motor_en)
        xchg({base[9:1], 16'h0000});
        `CHK("status0", CFG_ERR_STATUS, in_words[0])
        xchg(base);
        `CHK("mirror", base, in_words)
        `CHK("configured", 1'b1, configured)
        `CHK("cmd_accept", 1'b1, cmd_accept)
        `CHK("mode", 5'b11101, mode)
        in_current = 3'b011;
        repeat (4) @(posedge clk);
        #1;
        `CHK("in_active", 3'b001, in_active)
        `CHK("idle_held", 16'h0000, idle_current)
        move_done = 1'b1;
        @(posedge clk);
        #1;
        move_done = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        `CHK("idle_applied", base[7], idle_current)
        // Same values in both formats
        for (i = 0; i < 2; i++) begin
            cfg = base;
            cfg[1] = (i == 1) ? 16'h0305 : 16'h0005;
            xchg(cfg);
            wide_hi_in = (i == 1) ? 16'hd687 : 16'h04d2;
            wide_lo_in = (i == 1) ? 16'h0012 : 16'h0237;
            pos_in = -32'sd7654321;
            repeat (3) @(posedge clk);
            #1;
            `CHK("wide_param", 32'sd1234567, wide_param)
            `CHK("start_speed", 32'sd1234, start_speed)
            `CHK("pos_even", (i == 1) ? 16'h344f : 16'he21a, pos_rpt_even)
            `CHK("pos_odd", (i == 1) ? 16'hff8b : 16'hfebf, pos_rpt_odd)
            if (i == 1) begin
                desc_path = 1'b1;
                repeat (2) @(posedge clk);
                #1;
                `CHK("start_speed_desc", 32'sh00ea0001, start_speed)
                desc_path = 1'b0;
            end
        end
        // Last two entries are legal corner cases
        for (i = 0; i < 11; i++) begin
            do_reset(1'b0);
            cfg = base;
            cfg[cidx[i]] = cval[i];
            xchg(cfg);
            `CHK("accepted", i >= 9, configured)
        end
        do_reset(1'b0);
        cfg = base;
        cfg[3] = 16'h03e8;
        xchg(cfg);
        cfg[1] = 16'h0705;
        xchg(cfg);
        repeat (10) @(posedge clk);
        #1;
        `CHK("no_write", 0, n_wr)
        `CHK("no_halt", 1'b0, halted)
        flash_words = base;
        flash_words[8] = 16'h0020;
        flash_words[1] = 16'h0300;
        do_reset(1'b1);
        `CHK("flash_cfg", 1'b1, configured)
        cfg = base;
        cfg[1] = 16'h0b05;
        xchg(cfg);
        `CHK("fetch_img", 16'h0020, in_words[8])
        `CHK("fetch_mode", 5'b11000, mode)
        xchg(cfg);
        `CHK("fetch_refused", 5'b11000, mode)
        do_reset(1'b0);
        save(1'b0, SAVE_OK, LED_FLASH_GREEN);
        do_reset(1'b0);
        save(1'b1, SAVE_FAIL, LED_FLASH_RED);
        complete_run();
    end
endmodule // tb

`default_nettype wire
